// ===== rtl/sgsbc_defs.vh
`ifndef SGSBC_DEFS_VH
`define SGSBC_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SGSBC_OFF_GATE 12'h060
`define SGSBC_OFF_SUSP 12'h068
`define SGSBC_OFF_BCON1 12'h088
`define SGSBC_OFF_BFRAC1 12'h08c
`define SGSBC_OFF_BTIM1 12'h090
`define SGSBC_OFF_BCON2 12'h098
`define SGSBC_OFF_BFRAC2 12'h09c
`define SGSBC_OFF_BTIM2 12'h0a0

// ----------------------------------------
// Writable masks and reset values
// ----------------------------------------
`define SGSBC_GATE_MASK 32'h0000051f
`define SGSBC_GATE_RST 32'h00000000
`define SGSBC_SUSP_MASK 32'h000006df
`define SGSBC_SUSP_RST 32'h00000081
`define SGSBC_BAUD_CONTROL_RST 4'h0
`define SGSBC_FSEL_RST 5'h00
`define SGSBC_RELOAD_RST 11'h000

// ----------------------------------------
// Gating request bit positions
// ----------------------------------------
`define SGSBC_G_T21 10
`define SGSBC_G_SER2 8
`define SGSBC_G_GPT 4
`define SGSBC_G_T2 3
`define SGSBC_G_CAPCOMP 2
`define SGSBC_G_SER1 1
`define SGSBC_G_CONV1 0

// ----------------------------------------
// Suspend bit positions
// ----------------------------------------
`define SGSBC_S_CONV1 10
`define SGSBC_S_MEAS 9
`define SGSBC_S_EXTWD 7
`define SGSBC_S_T21 6
`define SGSBC_S_GPT 4
`define SGSBC_S_T2 3
`define SGSBC_S_PWMB 2
`define SGSBC_S_PWMA 1
`define SGSBC_S_INTWD 0
`define SGSBC_S_TOP 10

// ----------------------------------------
// Baud control fields
// ----------------------------------------
`define SGSBC_B_RUN 0
`define SGSBC_B_PRE_HI 3
`define SGSBC_B_PRE_LO 1
`define SGSBC_TIM_LO 16
`define SGSBC_TIM_HI 26
`define SGSBC_FRAC_TLO 5

`endif

// ===== rtl/sgsbc_baud_gen.v
`timescale 1ns/1ps
`default_nettype none

module sgsbc_baud_gen #(
  parameter RW = 11,
  parameter FW = 5,
  parameter PW = 3
) (
  input wire clk,
  input wire rst_n,
  input wire run,
  input wire [PW-1:0] prescale,
  input wire [RW-1:0] reload,
  input wire [FW-1:0] fracSel,
  output wire [RW-1:0] timerValue,
  output wire baudTick
);

  reg [4:0] preCnt_ff;
  reg [RW-1:0] timer_ff;
  reg [FW-1:0] acc_ff;
  reg extra_ff;
  reg runD_ff;
  reg tick_ff;
  reg [4:0] divMask;
  reg [FW:0] accSum;

  wire start = run & ~runD_ff;
  wire divTick = (preCnt_ff == divMask);

  // Reserved prescale codes fall back to the slowest division
  always @* begin
    case (prescale)
      3'h0: divMask = 5'h00;
      3'h1: divMask = 5'h01;
      3'h2: divMask = 5'h03;
      3'h3: divMask = 5'h07;
      3'h4: divMask = 5'h0f;
      default: divMask = 5'h1f;
    endcase
    accSum = {1'b0, acc_ff} + {1'b0, fracSel};
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      preCnt_ff <= 5'h00;
      timer_ff <= {RW{1'b0}};
      acc_ff <= {FW{1'b0}};
      extra_ff <= 1'b0;
      runD_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else begin
      runD_ff <= run;
      tick_ff <= 1'b0;
      if (start) begin
        // First cycle after run goes high: load reload, clear fraction accumulator
        timer_ff <= reload;
        acc_ff <= {FW{1'b0}};
        extra_ff <= 1'b0;
        preCnt_ff <= 5'h00;
      end else if (!run) begin
        preCnt_ff <= 5'h00;
      end else begin
        preCnt_ff <= divTick ? 5'h00 : preCnt_ff + 5'h01;
        if (divTick) begin
          if (reload == {RW{1'b0}}) begin
            tick_ff <= 1'b1;
          end else if (extra_ff) begin
            // Stretch one divided period to realise n/32
            extra_ff <= 1'b0;
          end else if (timer_ff <= {{(RW-1){1'b0}}, 1'b1}) begin
            tick_ff <= 1'b1;
            timer_ff <= reload;
            acc_ff <= accSum[FW-1:0];
            extra_ff <= accSum[FW];
          end else begin
            timer_ff <= timer_ff - {{(RW-1){1'b0}}, 1'b1};
          end
        end
      end
    end
  end

  assign timerValue = timer_ff;
  assign baudTick = tick_ff;

endmodule

`default_nettype wire

// ===== rtl/sgsbc_top.v
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sgsbc_defs.vh"

// Contract
// - Gating request bits for timers at 10,4,3
// - Gating request bits for serial, converter 8,1,0
// - Gating request bit 2 for capture/compare unit
// - Request held; peripheral synchronises its clock off
// - Suspend only during debug halt, per bit
// - Suspend gates counter clock only
// - Suspend bits 10,9,7 converter, measurement, watchdog
// - Suspend bits 6,4,3 for timers
// - Bit 2 suspend forces PWM B inactive
// - Bit 1 forces PWM A inactive, capture off
// - Internal watchdog bit 0; reset value 0x81
// - Two independent baud generator register sets
// - Prescaler bits 3:1 divide by 1 to 32
// - Run bit 0 enables the generator
// - Per generator 11-bit reload, 5-bit fraction
// - Low byte timer[2:0]+fraction; high upper timer
// - Load timer first cycle after run set
// - Fractional divider n/32 from bits 4:0
// - Fraction ignored when reload is zero
// - Reload zero bypasses timer; else reload count
// - Reload writes blocked while run is set
// - Reserved bits read as zero
module sgsbc_top #(
  parameter AW = 12,
  parameter RW = 11,
  parameter FW = 5,
  parameter PW = 3
) (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire dbgHalt,
  output wire timerTwentyoneOffReq,
  output wire serialChanTwoOffReq,
  output wire gpTimerBlockOffReq,
  output wire timerTwoOffReq,
  output wire capcompOffReq,
  output wire serialChanOneOffReq,
  output wire converterOneOffReq,
  output wire converterOneHalt,
  output wire measurementHalt,
  output wire extWatchdogHalt,
  output wire timerTwentyoneHalt,
  output wire gpTimerBlockHalt,
  output wire timerTwoHalt,
  output wire pwmTimerBHalt,
  output wire pwmTimerAHalt,
  output wire intWatchdogHalt,
  output wire pwmBOutInactive,
  output wire pwmAOutInactive,
  output wire captureADisable,
  output wire baudTickOne,
  output wire baudTickTwo
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [31:0] gateReg_ff;
  reg [31:0] suspReg_ff;
  reg [`SGSBC_S_TOP:0] halt_ff;
  reg pwmBOff_ff;
  reg pwmAOff_ff;
  reg capAOff_ff;
  reg [31:0] prdata_ff;
  reg pready_ff;
  reg pslverr_ff;
  reg [3:0] baud_control_ff [0:1];
  reg [FW-1:0] fsel_ff [0:1];
  reg [RW-1:0] reload_ff [0:1];
  wire [RW-1:0] timerVal [0:1];
  wire [1:0] tick;
  reg [31:0] nxt_prdata;
  reg nxt_pslverr;

  // ----------------------------------------
  // APB handshake
  // ----------------------------------------
  // Registered answer: pready rises in the first access cycle, so every
  // transfer completes with zero wait states.
  wire setup = psel & ~penable & ~pready_ff;
  wire wrEn = psel & penable & pready_ff & pwrite & ~pslverr_ff;
  wire hitGate = (paddr == `SGSBC_OFF_GATE);
  wire hitSusp = (paddr == `SGSBC_OFF_SUSP);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= setup;
      if (setup) begin
        pslverr_ff <= nxt_pslverr;
        prdata_ff <= pwrite ? 32'h00000000 : nxt_prdata;
      end else begin
        pslverr_ff <= 1'b0;
        prdata_ff <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  always @* begin
    nxt_prdata = 32'h00000000;
    nxt_pslverr = 1'b0;
    case (paddr)
      `SGSBC_OFF_GATE: nxt_prdata = gateReg_ff & `SGSBC_GATE_MASK;
      `SGSBC_OFF_SUSP: nxt_prdata = suspReg_ff & `SGSBC_SUSP_MASK;
      `SGSBC_OFF_BCON1: nxt_prdata = {28'h0000000, baud_control_ff[0]};
      `SGSBC_OFF_BCON2: nxt_prdata = {28'h0000000, baud_control_ff[1]};
      `SGSBC_OFF_BFRAC1: nxt_prdata = {24'h000000, timerVal[0][2:0], fsel_ff[0]};
      `SGSBC_OFF_BFRAC2: nxt_prdata = {24'h000000, timerVal[1][2:0], fsel_ff[1]};
      `SGSBC_OFF_BTIM1: nxt_prdata = {5'h00, timerVal[0], 5'h00, reload_ff[0]};
      `SGSBC_OFF_BTIM2: nxt_prdata = {5'h00, timerVal[1], 5'h00, reload_ff[1]};
      default: nxt_pslverr = 1'b1;
    endcase
  end

  // ----------------------------------------
  // Gating and suspend registers
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gateReg_ff <= `SGSBC_GATE_RST;
      suspReg_ff <= `SGSBC_SUSP_RST;
    end else begin
      // Request stays a level; the peripheral stops its own clock
      if (wrEn && hitGate) begin
        gateReg_ff <= pwdata & `SGSBC_GATE_MASK;
      end
      if (wrEn && hitSusp) begin
        suspReg_ff <= pwdata & `SGSBC_SUSP_MASK;
      end
    end
  end

  // Halt vector follows the debug halt level, so counting resumes from
  // the held value one cycle after halt drops; no reload on resume.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      halt_ff <= {(`SGSBC_S_TOP+1){1'b0}};
      pwmBOff_ff <= 1'b0;
      pwmAOff_ff <= 1'b0;
      capAOff_ff <= 1'b0;
    end else begin
      halt_ff <= suspReg_ff[`SGSBC_S_TOP:0] & {(`SGSBC_S_TOP+1){dbgHalt}};
      pwmBOff_ff <= dbgHalt & suspReg_ff[`SGSBC_S_PWMB];
      pwmAOff_ff <= dbgHalt & suspReg_ff[`SGSBC_S_PWMA];
      capAOff_ff <= dbgHalt & suspReg_ff[`SGSBC_S_PWMA];
    end
  end

  // ----------------------------------------
  // Baud generator register sets
  // ----------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : gBaud
      wire [AW-1:0] offCon = (ch == 0) ? `SGSBC_OFF_BCON1 : `SGSBC_OFF_BCON2;
      wire [AW-1:0] offFrac = (ch == 0) ? `SGSBC_OFF_BFRAC1 : `SGSBC_OFF_BFRAC2;
      wire [AW-1:0] offTim = (ch == 0) ? `SGSBC_OFF_BTIM1 : `SGSBC_OFF_BTIM2;
      wire running = baud_control_ff[ch][`SGSBC_B_RUN];

      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          baud_control_ff[ch] <= `SGSBC_BAUD_CONTROL_RST;
          fsel_ff[ch] <= `SGSBC_FSEL_RST;
          reload_ff[ch] <= `SGSBC_RELOAD_RST;
        end else begin
          if (wrEn && paddr == offCon) begin
            baud_control_ff[ch] <= pwdata[3:0];
          end
          if (wrEn && paddr == offFrac) begin
            fsel_ff[ch] <= pwdata[FW-1:0];
          end
          // Writes while running are dropped without an error answer
          if (wrEn && paddr == offTim && !running) begin
            reload_ff[ch] <= pwdata[RW-1:0];
          end
        end
      end

      sgsbc_baud_gen #(
        .RW(RW),
        .FW(FW),
        .PW(PW)
      ) uGen (
        .clk(clk),
        .rst_n(rst_n),
        .run(running),
        .prescale(baud_control_ff[ch][`SGSBC_B_PRE_HI:`SGSBC_B_PRE_LO]),
        .reload(reload_ff[ch]),
        .fracSel(fsel_ff[ch]),
        .timerValue(timerVal[ch]),
        .baudTick(tick[ch])
      );
    end
  endgenerate

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign timerTwentyoneOffReq = gateReg_ff[`SGSBC_G_T21];
  assign serialChanTwoOffReq = gateReg_ff[`SGSBC_G_SER2];
  assign gpTimerBlockOffReq = gateReg_ff[`SGSBC_G_GPT];
  assign timerTwoOffReq = gateReg_ff[`SGSBC_G_T2];
  assign capcompOffReq = gateReg_ff[`SGSBC_G_CAPCOMP];
  assign serialChanOneOffReq = gateReg_ff[`SGSBC_G_SER1];
  assign converterOneOffReq = gateReg_ff[`SGSBC_G_CONV1];
  assign converterOneHalt = halt_ff[`SGSBC_S_CONV1];
  assign measurementHalt = halt_ff[`SGSBC_S_MEAS];
  assign extWatchdogHalt = halt_ff[`SGSBC_S_EXTWD];
  assign timerTwentyoneHalt = halt_ff[`SGSBC_S_T21];
  assign gpTimerBlockHalt = halt_ff[`SGSBC_S_GPT];
  assign timerTwoHalt = halt_ff[`SGSBC_S_T2];
  assign pwmTimerBHalt = halt_ff[`SGSBC_S_PWMB];
  assign pwmTimerAHalt = halt_ff[`SGSBC_S_PWMA];
  assign intWatchdogHalt = halt_ff[`SGSBC_S_INTWD];
  assign pwmBOutInactive = pwmBOff_ff;
  assign pwmAOutInactive = pwmAOff_ff;
  assign captureADisable = capAOff_ff;
  assign baudTickOne = tick[0];
  assign baudTickTwo = tick[1];

endmodule

`default_nettype wire

// ===== dv/sgsbc_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// Peripheral timer and baud monitor
// --------------------------------
module sgsbc_far_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic gpTimerBlockOffReq,
  input wire logic gpTimerBlockHalt,
  input wire logic baudTickOne,
  input wire logic baudTickTwo,
  output logic [15:0] timerCount_ff,
  output logic [7:0] periodOne_ff,
  output logic [7:0] periodTwo_ff
);
  logic [7:0] sinceOne_ff;
  logic [7:0] sinceTwo_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timerCount_ff <= 16'h0;
      sinceOne_ff <= 8'h0;
      sinceTwo_ff <= 8'h0;
      periodOne_ff <= 8'h0;
      periodTwo_ff <= 8'h0;
    end else begin
      // Own gating is synchronous; resume keeps the held count, no reload
      if (!gpTimerBlockHalt && !gpTimerBlockOffReq) begin
        timerCount_ff <= timerCount_ff + 16'h1;
      end
      sinceOne_ff <= baudTickOne ? 8'h1 : sinceOne_ff + 8'h1;
      sinceTwo_ff <= baudTickTwo ? 8'h1 : sinceTwo_ff + 8'h1;
      if (baudTickOne) begin
        periodOne_ff <= sinceOne_ff;
      end
      if (baudTickTwo) begin
        periodTwo_ff <= sinceTwo_ff;
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/sgsbc_checker.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// Port checks
// --------------------------------
module sgsbc_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic dbgHalt,
  input wire logic capcompOffReq,
  input wire logic intWatchdogHalt,
  input wire logic converterOneHalt,
  input wire logic pwmTimerAHalt,
  input wire logic pwmTimerBHalt,
  input wire logic pwmBOutInactive,
  input wire logic pwmAOutInactive,
  input wire logic captureADisable,
  input wire logic baudTickTwo
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_ready_setup: assert property (psel && !penable |=> pready) else $error("no pready");
  a_err_ready: assert property (pslverr |-> pready) else $error("stray pslverr");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata idle");
  a_gate_held: assert property ($changed(capcompOffReq) |->
    $past(psel && penable && pwrite && pready)) else $error("gate changed");
  a_halt_needs_dbg: assert property (!dbgHalt |=>
    !(intWatchdogHalt || converterOneHalt || pwmTimerAHalt || pwmTimerBHalt))
    else $error("halt without debug");
  a_pwmb_inactive: assert property (pwmBOutInactive == pwmTimerBHalt)
    else $error("pwm b level");
  a_pwma_inactive: assert property (pwmAOutInactive == pwmTimerAHalt &&
    captureADisable == pwmTimerAHalt) else $error("pwm a level");
  a_pwm_need_dbg: assert property (!dbgHalt |=>
    !(pwmBOutInactive || pwmAOutInactive || captureADisable)) else $error("pwm off without debug");
  cover property (pslverr);
  cover property ($rose(pwmTimerAHalt));
  cover property (baudTickTwo);
endmodule
bind sgsbc_top sgsbc_checker u_chk (.clk, .rst_n, .psel, .penable, .pwrite, .prdata,
  .pready, .pslverr, .dbgHalt, .capcompOffReq, .intWatchdogHalt, .converterOneHalt,
  .pwmTimerAHalt, .pwmTimerBHalt, .pwmBOutInactive, .pwmAOutInactive, .captureADisable,
  .baudTickTwo);
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sgsbc_defs.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errCount++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} sgsbc_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic dbgHalt = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd;
  logic er;
  logic [15:0] held;
  int errCount = 0;
  int checks = 0;
  logic [7:0] ticks = 8'h00;
  wire [31:0] prdata;
  wire pready, pslverr, baudTickOne, baudTickTwo;
  wire timerTwentyoneOffReq, serialChanTwoOffReq, gpTimerBlockOffReq, timerTwoOffReq;
  wire capcompOffReq, serialChanOneOffReq, converterOneOffReq;
  wire converterOneHalt, measurementHalt, extWatchdogHalt, timerTwentyoneHalt;
  wire gpTimerBlockHalt, timerTwoHalt, pwmTimerBHalt, pwmTimerAHalt, intWatchdogHalt;
  wire pwmBOutInactive, pwmAOutInactive, captureADisable;
  wire [15:0] timerCount_ff;
  wire [7:0] periodOne_ff, periodTwo_ff;
  wire [6:0] offVec = {timerTwentyoneOffReq, serialChanTwoOffReq, gpTimerBlockOffReq,
    timerTwoOffReq, capcompOffReq, serialChanOneOffReq, converterOneOffReq};
  wire [8:0] haltVec = {converterOneHalt, measurementHalt, extWatchdogHalt, timerTwentyoneHalt,
    gpTimerBlockHalt, timerTwoHalt, pwmTimerBHalt, pwmTimerAHalt, intWatchdogHalt};
  wire [2:0] pwmVec = {pwmBOutInactive, pwmAOutInactive, captureADisable};
  sgsbc_row_t rows [9] = '{
    '{`SGSBC_OFF_GATE, 32'hffffffff, 32'h0000051f, 1'b0},
    '{`SGSBC_OFF_SUSP, 32'hffffffff, 32'h000006df, 1'b0},
    '{`SGSBC_OFF_BFRAC1, 32'hffffffff, 32'h0000001f, 1'b0},
    '{`SGSBC_OFF_BFRAC2, 32'h0000002a, 32'h0000000a, 1'b0},
    '{`SGSBC_OFF_BCON1, 32'hffffffff, 32'h0000000f, 1'b0},
    '{`SGSBC_OFF_BCON2, 32'h0000000b, 32'h0000000b, 1'b0},
    '{`SGSBC_OFF_BCON1, 32'h00000000, 32'h00000000, 1'b0},
    '{`SGSBC_OFF_BCON2, 32'h00000000, 32'h00000000, 1'b0},
    '{12'h004, 32'hffffffff, 32'h00000000, 1'b1}};
  sgsbc_top u_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .dbgHalt, .timerTwentyoneOffReq, .serialChanTwoOffReq, .gpTimerBlockOffReq,
    .timerTwoOffReq, .capcompOffReq, .serialChanOneOffReq, .converterOneOffReq,
    .converterOneHalt, .measurementHalt, .extWatchdogHalt, .timerTwentyoneHalt,
    .gpTimerBlockHalt, .timerTwoHalt, .pwmTimerBHalt, .pwmTimerAHalt, .intWatchdogHalt,
    .pwmBOutInactive, .pwmAOutInactive, .captureADisable, .baudTickOne, .baudTickTwo);
  sgsbc_far_model u_far (.clk, .rst_n, .gpTimerBlockOffReq, .gpTimerBlockHalt, .baudTickOne,
    .baudTickTwo, .timerCount_ff, .periodOne_ff, .periodTwo_ff);
  always #2 clk = ~clk;
  // --------------------------------
  // Bus and report tasks
  // --------------------------------
  task automatic wrapUp();
    if (errCount == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      errCount++;
      wrapUp();
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      `CHK(rd, rows[i].q)
      `CHK(er, rows[i].e)
    end
    // Second reset while registers hold non-default values
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `SGSBC_OFF_SUSP, 32'h0);
    `CHK(rd, 32'h00000081)
    `CHK(offVec, 7'h00)
    apb(1'b1, `SGSBC_OFF_GATE, 32'h0000051f);
    @(posedge clk);
    `CHK(offVec, 7'h7f)
    apb(1'b1, `SGSBC_OFF_GATE, 32'h00000004);
    @(posedge clk);
    `CHK(offVec, 7'h04)
    apb(1'b1, `SGSBC_OFF_SUSP, 32'h000006df);
    dbgHalt <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(haltVec, 9'h1ff)
    `CHK(pwmVec, 3'h7)
    held = timerCount_ff;
    repeat (4) @(posedge clk);
    `CHK(timerCount_ff, held)
    dbgHalt <= 1'b0;
    repeat (3) @(posedge clk);
    held = timerCount_ff;
    repeat (4) @(posedge clk);
    `CHK(timerCount_ff, held + 16'h4)
    apb(1'b1, `SGSBC_OFF_SUSP, 32'h00000002);
    dbgHalt <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(haltVec, 9'h002)
    `CHK(pwmVec, 3'h3)
    dbgHalt <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(haltVec, 9'h000)
    // Reload written only while stopped; div 32 keeps the timer still while read back
    apb(1'b1, `SGSBC_OFF_BTIM1, 32'hfffff5a5);
    apb(1'b1, `SGSBC_OFF_BCON1, 32'hb);
    apb(1'b0, `SGSBC_OFF_BTIM1, 32'h0);
    `CHK(rd, 32'h05a505a5)
    apb(1'b0, `SGSBC_OFF_BFRAC1, 32'h0);
    `CHK(rd, 32'h000000a0)
    apb(1'b1, `SGSBC_OFF_BCON1, 32'h0);
    apb(1'b1, `SGSBC_OFF_BTIM1, 32'h3);
    apb(1'b1, `SGSBC_OFF_BCON1, 32'h3);
    repeat (40) @(posedge clk);
    `CHK(periodOne_ff, 8'd6)
    apb(1'b1, `SGSBC_OFF_BTIM1, 32'h7);
    apb(1'b1, `SGSBC_OFF_BCON1, 32'h0);
    apb(1'b1, `SGSBC_OFF_BCON1, 32'h3);
    repeat (40) @(posedge clk);
    `CHK(periodOne_ff, 8'd6)
    // Fraction 31/32 stretches 31 of every 32 periods, from the third on, by one divided tick
    apb(1'b1, `SGSBC_OFF_BCON1, 32'h0);
    apb(1'b1, `SGSBC_OFF_BFRAC1, 32'h1f);
    apb(1'b1, `SGSBC_OFF_BCON1, 32'h3);
    repeat (60) @(posedge clk);
    `CHK(periodOne_ff, 8'd8)
    apb(1'b1, `SGSBC_OFF_BCON1, 32'h0);
    apb(1'b1, `SGSBC_OFF_BTIM1, 32'h0);
    apb(1'b1, `SGSBC_OFF_BFRAC1, 32'h10);
    apb(1'b1, `SGSBC_OFF_BCON1, 32'h5);
    repeat (40) @(posedge clk);
    `CHK(periodOne_ff, 8'd4)
    // A tick launched on the stopping edge is still visible one edge later
    apb(1'b1, `SGSBC_OFF_BCON1, 32'h0);
    @(posedge clk);
    repeat (40) begin
      @(posedge clk);
      ticks = ticks + {7'h00, baudTickOne};
    end
    `CHK(ticks, 8'h00)
    apb(1'b1, `SGSBC_OFF_BCON2, 32'hb);
    repeat (100) @(posedge clk);
    `CHK(periodTwo_ff, 8'd32)
    wrapUp();
  end
endmodule
`default_nettype wire
